/* hw/wdt_exec.sv */
// Execute logic for watchdog clear, complement-file and two compare-skip instructions.
// Assumes one core phase per enabled clock and a data memory that returns read data in Q2.
//
// What this block does
// RULE1 - Clear-watchdog opcode zeroes counter and postscaler
// RULE2 - Clear-watchdog sets timeout and powerdown flags
// RULE3 - Complement inverts byte, updates zero flag
// RULE4 - Destination bit zero writes working register
// RULE5 - Equal compare skips, flags untouched
// RULE6 - Greater unsigned compare skips, flags untouched
// RULE7 - Skip discards fetched instruction, runs nop
// RULE8 - Skipping compare adds one all-nop cycle
// RULE9 - Address low byte, destination bit eight
// RULE10 - Compares read Q2, evaluate Q3, no write
//
// Timing notes.
// One enabled clock edge is one core phase, so an instruction spans four edges.
// Every effect is registered, so each strobe shows one phase after the edge that
// decides it; the fetch side must allow for that lag.
// A skip is remembered across the Q4 edge and turns the whole next cycle into a
// no-operation cycle, whatever word the fetch side presents during it.
// Holding the clock enable low freezes every flip-flop, strobes included, so a
// strobe that is high when the enable drops stays high until it rises again.
`timescale 1ns/1ps
module wdt_exec
    import wdt_exec_pkg::*;
(
    input wire logic I_CLK,
    input wire logic I_NRST,
    input wire logic I_CE,
    input wire logic [15:0] I_INSTR,
    input wire logic [7:0] I_RDATA,
    output logic [7:0] O_ADDR,
    output logic O_RD,
    output logic O_WR,
    output logic [7:0] O_WDATA,
    output logic [7:0] O_WORKING_REG,
    output logic O_WDT_CLEAR,
    output logic O_SET_TO_PD,
    output logic O_ZERO_WE,
    output logic O_ZERO_VAL,
    output logic O_FLUSH,
    output logic [1:0] O_PHASE,
    output logic O_NOP_CYCLE
);
    // Decoded class of the current word and the compare flavour.
    op_e op;
    logic is_greater;

    // Phase count, skip memory and the cycle-wide no-operation marker.
    logic [1:0] phase_ff;
    logic skip_ff;
    logic nop_cycle_ff;

    // Captured operand, the internal working register and the derived values.
    logic [7:0] data_ff;
    logic [7:0] working_register_ff;
    logic [7:0] nxt_result;
    logic nxt_skip;

    ////////////////////////////////////////////////////////////////////////
    // Both compares subtract without sign; only the condition that ends the
    // subtraction differs, so one function serves both opcodes.
    function automatic logic skip_taken(
        input logic greater,
        input logic [7:0] file_byte,
        input logic [7:0] working_register
    );
        if (greater) begin
            return file_byte > working_register;
        end
        return file_byte == working_register;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // The decoder is purely combinational, so the word must stand for the
    // whole instruction cycle; a word that changes mid-cycle is not supported.
    wdt_exec_decode u_decode (
        .i_instr(I_INSTR),
        .o_op(op),
        .o_is_greater(is_greater)
    );

    // The inverse is formed from the captured byte, never from the live read bus,
    // because the bus carries junk once the read strobe has dropped.
    assign nxt_result = ~data_ff; // RULE3

    // Evaluated every phase but used only in Q3 of a compare.
    assign nxt_skip = skip_taken(is_greater, data_ff, working_register_ff); // RULE5 RULE6

    ////////////////////////////////////////////////////////////////////////
    // Phase counter. It wraps from Q4 to Q1 on its own, so the fetch side only
    // has to present a new word every fourth enabled edge after reset.
    always_ff @(posedge I_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            phase_ff <= PHASE_Q1;
        end else if (I_CE) begin
            phase_ff <= phase_ff + 2'h1;
        end
    end

    // The added cycle of a skip executes nothing; the fetched word is ignored.
    always_ff @(posedge I_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            nop_cycle_ff <= 1'b0;
        end else if (I_CE && phase_ff == PHASE_Q4) begin
            nop_cycle_ff <= skip_ff; // RULE8
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Memory reads and the captured operand.
    always_ff @(posedge I_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            O_ADDR <= 8'h00;
            O_RD <= 1'b0;
            data_ff <= 8'h00;
        end else if (I_CE) begin
            O_RD <= 1'b0;
            if (phase_ff == PHASE_Q1 && !nop_cycle_ff && op != OP_NONE) begin
                O_ADDR <= I_INSTR[ADDR_MSB:0]; // RULE9
                O_RD <= (op == OP_COMPLEMENT) || (op == OP_COMPARE); // RULE10
            end
            if (phase_ff == PHASE_Q2) begin
                data_ff <= I_RDATA; // RULE10
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Compare evaluation in Q3; the skip flag lives only until the Q4 edge, which hands it to the no-operation marker.
    always_ff @(posedge I_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            skip_ff <= 1'b0;
            O_FLUSH <= 1'b0;
        end else if (I_CE) begin
            O_FLUSH <= 1'b0;
            if (phase_ff == PHASE_Q3 && !nop_cycle_ff && op == OP_COMPARE) begin
                skip_ff <= nxt_skip; // RULE5 RULE6
                O_FLUSH <= nxt_skip; // RULE7
            end else if (phase_ff == PHASE_Q4) begin
                skip_ff <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Writes in Q4: complement only; compares never write.
    // The strobe is raised at the Q3 edge so that memory takes it at the Q4 edge,
    // while the address loaded in Q1 still stands.
    always_ff @(posedge I_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            O_WR <= 1'b0;
            O_WDATA <= 8'h00;
            working_register_ff <= WORKING_REG_RESET;
            O_ZERO_WE <= 1'b0;
            O_ZERO_VAL <= 1'b0;
        end else if (I_CE) begin
            O_WR <= 1'b0;
            O_ZERO_WE <= 1'b0;
            if (phase_ff == PHASE_Q3 && !nop_cycle_ff && op == OP_COMPLEMENT) begin
                O_ZERO_WE <= 1'b1; // RULE3
                O_ZERO_VAL <= nxt_result == 8'h00; // RULE3
                if (I_INSTR[DEST_BIT]) begin // RULE9
                    O_WR <= 1'b1; // RULE4
                    O_WDATA <= nxt_result;
                end else begin
                    working_register_ff <= nxt_result; // RULE4
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Watchdog clear is issued as a single-phase pulse in Q3.
    always_ff @(posedge I_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            O_WDT_CLEAR <= 1'b0;
            O_SET_TO_PD <= 1'b0;
        end else if (I_CE) begin
            O_WDT_CLEAR <= 1'b0;
            O_SET_TO_PD <= 1'b0;
            if (phase_ff == PHASE_Q2 && !nop_cycle_ff && op == OP_CLEAR_WATCHDOG) begin
                O_WDT_CLEAR <= 1'b1; // RULE1
                O_SET_TO_PD <= 1'b1; // RULE2
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status mirrors. Each is one phase behind its internal source, which keeps
    // every output on a flip-flop at the cost of that lag.
    always_ff @(posedge I_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            O_PHASE <= PHASE_Q1;
        end else if (I_CE) begin
            O_PHASE <= phase_ff;
        end
    end

    always_ff @(posedge I_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            O_NOP_CYCLE <= 1'b0;
        end else if (I_CE) begin
            O_NOP_CYCLE <= nop_cycle_ff; // RULE8
        end
    end

    // Compares read the internal register, so the lag here never reaches a result.
    always_ff @(posedge I_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            O_WORKING_REG <= WORKING_REG_RESET;
        end else if (I_CE) begin
            O_WORKING_REG <= working_register_ff;
        end
    end
endmodule // wdt_exec

/* hw/wdt_exec_decode.sv */
// Combinational opcode decoder for the four supported instructions.
// Assumes the instruction word is stable for the whole instruction cycle.
`timescale 1ns/1ps
module wdt_exec_decode
    import wdt_exec_pkg::*;
(
    input wire logic [15:0] i_instr,
    output op_e o_op,
    output logic o_is_greater
);
    always_comb begin
        o_op = OP_NONE;
        o_is_greater = 1'b0;
        if (i_instr == CLEAR_WATCHDOG_OP_WORD) begin
            o_op = OP_CLEAR_WATCHDOG; // RULE1
        end else if (i_instr[15:9] == COMPLEMENT_FILE_OP_HI) begin
            o_op = OP_COMPLEMENT; // RULE3
        end else if (i_instr[15:8] == COMPARE_SKIP_EQUAL_OP_HI) begin
            o_op = OP_COMPARE; // RULE5
        end else if (i_instr[15:8] == COMPARE_SKIP_GREATER_OP_HI) begin
            o_op = OP_COMPARE; // RULE6
            o_is_greater = 1'b1;
        end
    end
endmodule // wdt_exec_decode

/* hw/wdt_exec_pkg.sv */
// Constants for the watchdog-clear, complement and compare-skip executor.
// Assumes a core with a four-phase instruction cycle and 16-bit instruction words.
package wdt_exec_pkg;
    localparam logic [15:0] CLEAR_WATCHDOG_OP_WORD = 16'h0004;
    localparam logic [6:0] COMPLEMENT_FILE_OP_HI = 7'h09;
    localparam logic [7:0] COMPARE_SKIP_EQUAL_OP_HI = 8'h31;
    localparam logic [7:0] COMPARE_SKIP_GREATER_OP_HI = 8'h32;
    localparam int DEST_BIT = 8;
    localparam int ADDR_MSB = 7;
    localparam logic [7:0] WORKING_REG_RESET = 8'h00;
    localparam logic [1:0] PHASE_Q1 = 2'h0;
    localparam logic [1:0] PHASE_Q2 = 2'h1;
    localparam logic [1:0] PHASE_Q3 = 2'h2;
    localparam logic [1:0] PHASE_Q4 = 2'h3;
    typedef enum logic [3:0] {
        OP_NONE = 4'b0001,
        OP_CLEAR_WATCHDOG = 4'b0010,
        OP_COMPLEMENT = 4'b0100,
        OP_COMPARE = 4'b1000
    } op_e;
endpackage

/* sim/data_mem_model.sv */
// Data memory that answers the block's reads and writes.
// Assumes read data is needed while the read strobe is high.
`timescale 1ns/1ps
module data_mem_model (
    input wire logic i_clk,
    input wire logic i_rd,
    input wire logic i_wr,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    output logic [7:0] o_rdata
);
    logic [7:0] mem [256];
    logic [7:0] junk_ff = 8'h5a;
    initial for (int a = 0; a < 256; a++) mem[a] = a[7:0];
    // Outside a read the bus keeps changing, so stale data is never trusted.
    assign o_rdata = i_rd ? mem[i_addr] : junk_ff;
    always @(posedge i_clk) begin
        junk_ff <= ~o_rdata;
        if (i_wr) mem[i_addr] <= i_wdata;
    end
endmodule // data_mem_model

/* sim/wdt_exec_bench.sv */
// Table-driven bench for the execute block; memory holds its own address.
// Assumes one instruction every four enabled edges, aligned to reset release.
`timescale 1ns/1ps
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin err_total++; \
    $display("wrong value %s exp %h got %h", n, e, s); end end
module wdt_exec_bench;
    logic I_CLK, I_NRST, I_CE, O_RD, O_WR, O_WDT_CLEAR, O_SET_TO_PD, O_ZERO_WE, O_ZERO_VAL;
    logic O_FLUSH, O_NOP_CYCLE;
    logic [15:0] I_INSTR;
    logic [7:0] I_RDATA, O_ADDR, O_WDATA, O_WORKING_REG, w;
    logic [6:0] fl;
    logic [1:0] O_PHASE;
    int err_total, checked;
    typedef struct {logic [15:0] ins; logic [6:0] fl; logic [7:0] w;} row_s;
    row_s rows[16] = '{'{16'h0004, 7'h60, 8'h00}, '{16'h1212, 7'h04, 8'hed},
        '{16'h12ff, 7'h06, 8'h00}, '{16'h3100, 7'h08, 8'h00}, '{16'h0004, 7'h01, 8'h00},
        '{16'h3201, 7'h08, 8'h00}, '{16'h1330, 7'h01, 8'h00}, '{16'h3200, 7'h00, 8'h00},
        '{16'h3101, 7'h00, 8'h00}, '{16'h1330, 7'h14, 8'h00}, '{16'h1230, 7'h04, 8'h30},
        '{16'h3231, 7'h08, 8'h30}, '{16'h0004, 7'h01, 8'h30}, '{16'h322f, 7'h00, 8'h30},
        '{16'h3130, 7'h00, 8'h30}, '{16'h3300, 7'h00, 8'h30}};
    wdt_exec dut_u (.I_CLK(I_CLK), .I_NRST(I_NRST), .I_CE(I_CE), .I_INSTR(I_INSTR),
        .I_RDATA(I_RDATA), .O_ADDR(O_ADDR), .O_RD(O_RD), .O_WR(O_WR), .O_WDATA(O_WDATA),
        .O_WORKING_REG(O_WORKING_REG), .O_WDT_CLEAR(O_WDT_CLEAR), .O_SET_TO_PD(O_SET_TO_PD),
        .O_ZERO_WE(O_ZERO_WE), .O_ZERO_VAL(O_ZERO_VAL), .O_FLUSH(O_FLUSH), .O_PHASE(O_PHASE),
        .O_NOP_CYCLE(O_NOP_CYCLE));
    data_mem_model mem_u (.i_clk(I_CLK), .i_rd(O_RD), .i_wr(O_WR), .i_addr(O_ADDR),
        .i_wdata(O_WDATA), .o_rdata(I_RDATA));
    task automatic run(input logic [15:0] ins, output logic [6:0] f, output logic [7:0] wr);
        f = '0;
        I_INSTR <= ins;
        for (int k = 0; k < 3; k++) begin
            @(posedge I_CLK);
            @(negedge I_CLK);
            if (k == 0) wr = O_WORKING_REG;
            f |= {O_WDT_CLEAR, O_SET_TO_PD, O_WR, O_FLUSH, O_ZERO_WE, O_ZERO_WE & O_ZERO_VAL,
                k == 2 && O_NOP_CYCLE};
        end
        @(posedge I_CLK);
    endtask
    task automatic results();
        $display("checked %0d err_total %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        I_CLK = 0;
        forever #25 I_CLK = ~I_CLK;
    end
    initial begin
        I_NRST = 0;
        I_CE = 1;
        I_INSTR = '0;
        repeat (3) @(posedge I_CLK);
        `CHK("reset", 12'h000, {O_RD, O_WR, O_FLUSH, O_WDT_CLEAR, O_WORKING_REG})
        I_NRST <= 1;
        for (int i = 0; i < 16; i++) begin
            run(rows[i].ins, fl, w);
            `CHK("flags", rows[i].fl, fl)
            if (i > 0) `CHK("working_register", rows[i - 1].w, w)
        end
        // Freeze after Q2: the clear pulse and the phase mirror must hold.
        I_INSTR <= 16'h0004;
        repeat (2) @(posedge I_CLK);
        I_CE <= 0;
        repeat (3) @(posedge I_CLK);
        @(negedge I_CLK);
        `CHK("frozen", 4'hd, {O_WDT_CLEAR, O_SET_TO_PD, O_PHASE})
        // Reset in mid-run; the phase count must realign to the first edge after it.
        @(posedge I_CLK);
        I_NRST <= 0;
        I_CE <= 1;
        repeat (3) @(posedge I_CLK);
        `CHK("reset2", 14'h0000, {O_WDT_CLEAR, O_NOP_CYCLE, O_PHASE, O_WORKING_REG, O_ZERO_WE, O_WR})
        I_NRST <= 1;
        run(16'h1321, fl, w);
        `CHK("flags d1", 7'h14, fl)
        `CHK("write", 16'h21de, {O_ADDR, O_WDATA})
        run(16'h1221, fl, w);
        `CHK("flags d0", 7'h04, fl)
        run(16'h0000, fl, w);
        `CHK("working_register d0", 8'h21, w)
        results();
    end
endmodule // wdt_exec_bench
bind wdt_exec wdt_exec_sva chk_u (.I_CLK, .I_NRST, .I_CE, .O_ADDR, .O_RD, .O_WR, .O_WDATA,
    .O_WDT_CLEAR, .O_SET_TO_PD, .O_ZERO_WE, .O_ZERO_VAL, .O_FLUSH, .O_NOP_CYCLE);

/* sim/wdt_exec_sva.sv */
// Port checker for the execute block.
// Assumes nothing is checked while the clock enable is low or reset is applied.
`timescale 1ns/1ps
module wdt_exec_sva (
    input wire logic I_CLK,
    input wire logic I_NRST,
    input wire logic I_CE,
    input wire logic [7:0] O_ADDR,
    input wire logic O_RD,
    input wire logic O_WR,
    input wire logic [7:0] O_WDATA,
    input wire logic O_WDT_CLEAR,
    input wire logic O_SET_TO_PD,
    input wire logic O_ZERO_WE,
    input wire logic O_ZERO_VAL,
    input wire logic O_FLUSH,
    input wire logic O_NOP_CYCLE
);
    default clocking @(posedge I_CLK); endclocking
    default disable iff (!I_NRST || !I_CE);
    a_wdt_flag_pair: assert property (O_WDT_CLEAR == O_SET_TO_PD)
        else $error("flag set apart from clear");
    a_wdt_no_mem: assert property (O_WDT_CLEAR |-> !O_WR && !O_ZERO_WE && !$past(O_RD))
        else $error("clear touched memory");
    a_rd_pulse: assert property (O_RD |=> !O_RD && $stable(O_ADDR))
        else $error("read strobe too long");
    a_wr_after_rd: assert property (O_WR |-> $past(O_RD, 2))
        else $error("write without read");
    a_wr_zero: assert property (O_WR |-> O_ZERO_WE && O_ZERO_VAL == (O_WDATA == 8'h00))
        else $error("zero flag mismatch");
    a_flush_no_write: assert property (O_FLUSH |-> $past(O_RD, 2) && !O_WR && !O_ZERO_WE)
        else $error("compare wrote");
    a_flush_then_nop: assert property (O_FLUSH |-> ##[1:4] O_NOP_CYCLE)
        else $error("no nop after skip");
    a_nop_quiet: assert property (O_NOP_CYCLE && $past(O_NOP_CYCLE)
        |-> !O_WR && !O_FLUSH && !O_WDT_CLEAR && !O_ZERO_WE)
        else $error("activity in nop cycle");
    c_skip: cover property (O_FLUSH);
    c_write: cover property (O_WR);
    c_clear: cover property (O_WDT_CLEAR);
endmodule // wdt_exec_sva
